// >>> out_sink.sv
// Output consumer model standing behind the sample port of the routing block.
// Assumes words are handed over on a rising edge while valid and ready are both high.
`timescale 1ns/1ps
module out_sink
  import output_routing_pkg::*;
(
  input  wire logic      ref_clk_in,
  input  wire logic      resetn_in,
  input  wire logic      stall_in,
  input  wire out_word_t word_in,
  input  wire logic      valid_in,
  output logic           ready_out
);
  out_word_t words[$];

  initial ready_out = 1'b0;

  // Ready moves on the falling edge only, so a stall never cuts a word in half.
  always @(negedge ref_clk_in)
    ready_out <= resetn_in && !stall_in;

  always @(posedge ref_clk_in)
    if (resetn_in && valid_in && ready_out)
      words.push_back(word_in);
endmodule

// >>> output_routing_control.sv
// Output routing control: device and routing registers, channel summers, cascade
// alignment, output formatting and a 32-word output FIFO.
// Assumes channel samples, cascade input and host strobes are synchronous to ref_clk_in.
`timescale 1ns/1ps

module sample_fifo #(
  parameter int WIDTH = 82,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk_in,
  input  wire logic             resetn_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0]   count;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count != (PTR_W+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;
  assign out_data_out  = mem[rd_ptr];

  always_ff @(posedge ref_clk_in)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    end
  end

  // Overflow guard.
  property p_no_push_when_full;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (count == (PTR_W+1)'(DEPTH)) |-> !in_ready_out;
  endproperty
  a_no_push_when_full: assert property (p_no_push_when_full)
    else $error("FIFO accepted a word while full");
endmodule

// Notes on behaviour
// - Immediate-update bit copies routing master to slave four clocks after a write.
// - Bit 14 enters self-test; zero leaves it off; bits 13 to 11 unused.
// - Doubled-rate select alternates I and Q data on successive outputs.
// - Doubled-rate select only acts in output mode 01.
// - Mode field picks cascade, four I, four Q, or four muxed I/Q lanes.
// - Bit 7 selects sync output polarity, rising or falling assertion.
// - Output enable low replaces every output lane with zeros.
// - I strobe enable marks the samples that carry I data in muxed output.
// - I strobe polarity chooses whether I data coincides with strobe high or low.
// - Cascade enable admits cascade buses, else zero; host clears it outside cascade.
// - Cascade delay aligns the four-channel sum for master or slave position.
// - Broadcast bit sends a channel write to all four channels.
// - Mode 01 without doubled rate, with complex channel 0 or 2, gives parallel I and Q lanes.
// - Routing register holds four 4-bit fields, summer 4 in the top bit.
// - A routing bit set adds that channel into that summer.
// - Any channel can reach any summer in real, imaginary or muxed modes.
module output_routing_control
  import output_routing_pkg::*;
#(
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  input  wire logic                   ref_clk_in,
  input  wire logic                   resetn_in,
  input  wire logic [ADDR_W-1:0]      host_addr_in,
  input  wire logic [DATA_W-1:0]      host_wdata_in,
  input  wire logic                   host_wr_in,
  input  wire logic                   host_rd_in,
  output logic [DATA_W-1:0]           host_rdata_out,
  input  wire logic [1:0]             chan_sel_in,
  output logic [NUM_CH-1:0]           chan_wr_out,
  input  wire logic                   update_in,
  output logic                        bist_mode_out,
  input  wire iq_t [NUM_CH-1:0]       chan_in,
  input  wire logic                   chan_valid_in,
  output logic                        chan_ready_out,
  input  wire logic                   complex_ch0_in,
  input  wire logic                   complex_ch2_in,
  input  wire iq_t                    casc_in,
  input  wire logic                   sync_in,
  output out_word_t                   out_word_out,
  output logic                        out_valid_out,
  input  wire logic                   out_ready_in
);
  localparam int WORD_W = $bits(out_word_t);

  logic [DATA_W-1:0]     dev_ctrl;
  logic [DATA_W-1:0]     route_master;
  logic [DATA_W-1:0]     route_slave;
  logic [2:0]            imm_cnt;
  logic                  phase_i;
  iq_t [NUM_SUM-1:0]     sum;
  iq_t [MAX_CASC_DLY-1:0] dly_line;
  iq_t                   dly_sum;
  iq_t                   casc_gated;
  iq_t                   casc_total;
  out_word_t             next_word;
  out_word_t             fifo_word;
  logic                  fifo_valid;
  logic                  fifo_ready;
  logic                  accept;
  logic                  wr_ctrl;
  logic                  wr_route;
  out_mode_t             mode;
  logic [1:0]            casc_dly;
  logic                  x2_active;
  logic                  mux_active;

  assign wr_ctrl    = host_wr_in & (host_addr_in == DEV_CTRL_ADDR);
  assign wr_route   = host_wr_in & (host_addr_in == ROUTING_ADDR);
  assign mode       = out_mode_t'(dev_ctrl[MODE_LSB +: 2]);
  assign casc_dly   = dev_ctrl[CASC_DLY_LSB +: 2];
  assign x2_active  = dev_ctrl[X2_BIT] & (mode == MODE_REAL);
  assign mux_active = x2_active | (mode == MODE_MUXED);
  assign accept     = chan_valid_in & chan_ready_out;
  assign bist_mode_out = dev_ctrl[BIST_BIT];

  always_comb
  begin
    chan_wr_out = '0;
    if (host_wr_in && host_addr_in < DEV_CTRL_ADDR)
    begin
      if (dev_ctrl[BCAST_BIT])
      begin
        chan_wr_out = '1;
      end
      else
      begin
        chan_wr_out[chan_sel_in] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      dev_ctrl     <= DEV_CTRL_RESET;
      route_master <= ROUTING_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        dev_ctrl <= host_wdata_in & DEV_CTRL_MASK;
      end
      if (wr_route)
      begin
        route_master <= host_wdata_in;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      imm_cnt     <= '0;
      route_slave <= ROUTING_RESET;
    end
    else if (wr_route && dev_ctrl[IMM_BIT])
    begin
      imm_cnt <= 3'(IMM_SYNC_CYCLES - 1);
    end
    else if (imm_cnt != '0)
    begin
      imm_cnt <= imm_cnt - 1'b1;
      if (imm_cnt == 3'd1)
      begin
        route_slave <= route_master;
      end
    end
    else if (update_in)
    begin
      route_slave <= route_master;
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      host_rdata_out <= '0;
    end
    else if (host_rd_in)
    begin
      unique case (host_addr_in)
        DEV_CTRL_ADDR: host_rdata_out <= dev_ctrl;
        ROUTING_ADDR:  host_rdata_out <= route_master;
        default:       host_rdata_out <= '0;
      endcase
    end
  end

  // field layout, and any channel to any summer.
  for (genvar s = 0; s < NUM_SUM; s++)
  begin : g_summer
    always_comb
    begin
      sum[s] = '0;
      for (int c = 0; c < NUM_CH; c++)
      begin
        if (route_slave[c*ROUTE_FIELD_W + s])
        begin
          sum[s].i = sum[s].i + chan_in[c].i;
          sum[s].q = sum[s].q + chan_in[c].q;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      dly_line <= '0;
    end
    else if (accept)
    begin
      dly_line <= {dly_line[MAX_CASC_DLY-2:0], sum[0]};
    end
  end

  assign dly_sum = (casc_dly == 2'b00) ? sum[0] : dly_line[casc_dly - 2'd1];

  assign casc_gated   = dev_ctrl[CASC_EN_BIT] ? casc_in : '0;
  assign casc_total.i = dly_sum.i + casc_gated.i;
  assign casc_total.q = dly_sum.q + casc_gated.q;

  // I first, then Q, alternating per sample.
  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      phase_i <= 1'b1;
    end
    else if (!mux_active)
    begin
      phase_i <= 1'b1;
    end
    else if (accept)
    begin
      phase_i <= ~phase_i;
    end
  end

  always_comb
  begin
    next_word = '0;
    for (int s = 0; s < NUM_SUM; s++)
    begin
      unique case (mode)
        MODE_CASCADE: next_word.lane[s] = '0;
        MODE_REAL:    next_word.lane[s] = x2_active ? (phase_i ? sum[s].i : sum[s].q)
                                                     : sum[s].i;
        MODE_IMAG:    next_word.lane[s] = sum[s].q;
        MODE_MUXED:   next_word.lane[s] = phase_i ? sum[s].i : sum[s].q;
      endcase
    end
    if (mode == MODE_CASCADE)
    begin
      next_word.lane[0] = casc_total.i;
      next_word.lane[1] = casc_total.q;
    end
    if (mode == MODE_REAL && !x2_active)
    begin
      if (complex_ch0_in)
      begin
        next_word.lane[0] = sum[0].i;
        next_word.lane[1] = sum[0].q;
      end
      if (complex_ch2_in)
      begin
        next_word.lane[2] = sum[2].i;
        next_word.lane[3] = sum[2].q;
      end
    end
    if (!dev_ctrl[OUT_EN_BIT])
    begin
      next_word.lane = '0;
    end
    // and strobe marks I samples at chosen level.
    if (dev_ctrl[ISTB_EN_BIT] && mux_active)
    begin
      next_word.istrobe = phase_i ? dev_ctrl[ISTB_POL_BIT] : ~dev_ctrl[ISTB_POL_BIT];
    end
    next_word.sync = sync_in ^ dev_ctrl[SYNC_POL_BIT];
  end

  // A stalled consumer fills the FIFO and then holds off the channel data path.
  sample_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (FIFO_WORDS)
  ) u_fifo (
    .ref_clk_in    (ref_clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (chan_valid_in),
    .in_ready_out  (chan_ready_out),
    .in_data_in    (next_word),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_ready),
    .out_data_out  (fifo_word)
  );

  assign fifo_ready = ~out_valid_out | out_ready_in;

  always_ff @(posedge ref_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      out_valid_out <= 1'b0;
      out_word_out  <= '0;
    end
    else if (fifo_ready)
    begin
      out_valid_out <= fifo_valid;
      if (fifo_valid)
      begin
        out_word_out <= fifo_word;
      end
    end
  end

  property p_imm_update;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (wr_route && dev_ctrl[IMM_BIT] ##1 (!host_wr_in)[*3])
      |-> ##1 (route_slave == $past(host_wdata_in, 4));
  endproperty
  a_imm_update: assert property (p_imm_update)
    else $error("Immediate routing update not applied after four clocks");

  property p_masked_update;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (wr_route && !dev_ctrl[IMM_BIT] && !update_in && imm_cnt == '0) |=> $stable(route_slave);
  endproperty
  a_masked_update: assert property (p_masked_update)
    else $error("Routing slave changed without an update");

  property p_bist_write;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    wr_ctrl |=> (bist_mode_out == $past(host_wdata_in[BIST_BIT]))
            && (dev_ctrl[13:11] == 3'h0);
  endproperty
  a_bist_write: assert property (p_bist_write)
    else $error("Self-test bit or unused bits wrong after write");

  property p_x2_alternate;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (accept && x2_active ##1 x2_active) |-> (phase_i != $past(phase_i));
  endproperty
  a_x2_alternate: assert property (p_x2_alternate)
    else $error("Doubled-rate output did not alternate I and Q");

  property p_out_disable;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    !dev_ctrl[OUT_EN_BIT] |-> (next_word.lane == '0);
  endproperty
  a_out_disable: assert property (p_out_disable)
    else $error("Output data not zero while disabled");

  property p_strobe_pol;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (dev_ctrl[ISTB_EN_BIT] && mux_active && phase_i)
      |-> (next_word.istrobe == dev_ctrl[ISTB_POL_BIT]);
  endproperty
  a_strobe_pol: assert property (p_strobe_pol)
    else $error("I strobe level does not match polarity");

  property p_casc_gate;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (mode == MODE_CASCADE && !dev_ctrl[CASC_EN_BIT] && casc_dly == 2'b00 &&
     dev_ctrl[OUT_EN_BIT]) |-> (next_word.lane[0] == sum[0].i);
  endproperty
  a_casc_gate: assert property (p_casc_gate)
    else $error("Disabled cascade input leaked into output");

  property p_casc_delay;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (accept && casc_dly == 2'b01 ##1 casc_dly == 2'b01) |-> (dly_sum == $past(sum[0]));
  endproperty
  a_casc_delay: assert property (p_casc_delay)
    else $error("First slave delay is not one sample");

  property p_broadcast;
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (host_wr_in && host_addr_in < DEV_CTRL_ADDR && dev_ctrl[BCAST_BIT])
      |-> (chan_wr_out == 4'hF);
  endproperty
  a_broadcast: assert property (p_broadcast)
    else $error("Broadcast write not sent to all channels");
endmodule

// >>> output_routing_pkg.sv
// Shared constants, modes and data carriers for the output routing control block.
// Assumes a single 125 MHz device clock and a 7-bit word-addressed host register port.
package output_routing_pkg;

  localparam int SAMPLE_W = 20;
  localparam int NUM_CH   = 4;
  localparam int NUM_SUM  = 4;
  localparam int ADDR_W   = 7;
  localparam int DATA_W   = 16;
  localparam int FIFO_DEPTH = 32;

  localparam real CLK_PERIOD_NS = 8.0;

  localparam logic [ADDR_W-1:0] DEV_CTRL_ADDR = 7'h78;
  localparam logic [ADDR_W-1:0] ROUTING_ADDR  = 7'h79;

  localparam logic [DATA_W-1:0] DEV_CTRL_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] ROUTING_RESET  = 16'h0000;
  localparam logic [DATA_W-1:0] DEV_CTRL_MASK  = 16'hC7FF;

  localparam int IMM_BIT      = 15;
  localparam int BIST_BIT     = 14;
  localparam int X2_BIT       = 10;
  localparam int MODE_LSB     = 8;
  localparam int SYNC_POL_BIT = 7;
  localparam int OUT_EN_BIT   = 6;
  localparam int ISTB_EN_BIT  = 5;
  localparam int ISTB_POL_BIT = 4;
  localparam int CASC_EN_BIT  = 3;
  localparam int CASC_DLY_LSB = 1;
  localparam int BCAST_BIT    = 0;
  localparam int ROUTE_FIELD_W = 4;

  localparam int IMM_SYNC_CYCLES = 4;
  localparam int MAX_CASC_DLY    = 3;

  typedef enum logic [1:0] {
    MODE_CASCADE = 2'b00,
    MODE_REAL    = 2'b01,
    MODE_IMAG    = 2'b10,
    MODE_MUXED   = 2'b11
  } out_mode_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] i;
    logic [SAMPLE_W-1:0] q;
  } iq_t;

  typedef struct packed {
    logic [NUM_SUM-1:0][SAMPLE_W-1:0] lane;
    logic                             istrobe;
    logic                             sync;
  } out_word_t;

endpackage

// >>> tb_output_routing_control.sv
// Self-checking bench for the output routing control block.
// Assumes the consumer model out_sink and a 125 MHz clock.
`timescale 1ns/1ps
module tb_output_routing_control
  import output_routing_pkg::*;
;
  localparam int FW = 32;
  logic                    clk, rstn, wr, rd, upd, cv, c0, c2, stall, sy;
  logic [ADDR_W-1:0]       addr;
  logic [DATA_W-1:0]       wd, rdata, ctrl, rt, rtm;
  logic [1:0]              sel;
  logic [NUM_CH-1:0]       cwr;
  logic                    bist, crdy, ovld, ordy;
  iq_t [NUM_CH-1:0]        ch;
  iq_t                     casc;
  out_word_t               ow;
  int                      num_errors, num_checks, n;

  output_routing_control #(.FIFO_WORDS(FW)) u_output_routing_control (
    .ref_clk_in(clk), .resetn_in(rstn), .host_addr_in(addr), .host_wdata_in(wd),
    .host_wr_in(wr), .host_rd_in(rd), .host_rdata_out(rdata), .chan_sel_in(sel),
    .chan_wr_out(cwr), .update_in(upd), .bist_mode_out(bist), .chan_in(ch),
    .chan_valid_in(cv), .chan_ready_out(crdy), .complex_ch0_in(c0),
    .complex_ch2_in(c2), .casc_in(casc), .sync_in(sy), .out_word_out(ow),
    .out_valid_out(ovld), .out_ready_in(ordy));

  out_sink u_out_sink (.ref_clk_in(clk), .resetn_in(rstn), .stall_in(stall),
    .word_in(ow), .valid_in(ovld), .ready_out(ordy));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(logic [15:0] g, logic [15:0] e, string m);
    num_checks++;
    if (g !== e)
      $display("mismatch at %0t: %s got %h want %h", $time, m, g, e);
    if (g !== e)
      num_errors++;
  endtask

  task automatic wreg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    if (a == 7'h78)
      ctrl = d & 16'hC7FF;
    if (a == 7'h79)
      rtm = d;
    #1;
    if (a < 7'h78)
      cmp(16'(cwr), ctrl[0] ? 16'hF : 16'(4'b1 << sel), "chan write");
    @(negedge clk);
    wr = 1'b0;
  endtask

  task automatic rreg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    cmp(rdata, e, "read");
  endtask

  task automatic update;
    @(negedge clk);
    upd = 1'b1;
    @(negedge clk);
    upd = 1'b0;
    rt = rtm;
  endtask

  // Channel c carries distinct powers of two, so every routing mix sums uniquely.
  task automatic push(bit z);
    int k;
    k = 0;
    @(negedge clk);
    for (int c = 0; c < NUM_CH; c++)
      ch[c] = z ? iq_t'{i: 20'h0, q: 20'h0} : iq_t'{i: 20'h10 << c, q: 20'h1 << c};
    // Sync flips per sample so both output levels are seen under each polarity.
    sy = ~sy;
    cv = 1'b1;
    while (crdy !== 1'b1 && k < 100)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 100)
    begin
      num_errors++;
      $display("mismatch at %0t: sample never accepted", $time);
    end
    @(negedge clk);
    cv = 1'b0;
  endtask

  function automatic logic [SAMPLE_W-1:0] ssum(int s, bit q);
    ssum = '0;
    for (int c = 0; c < NUM_CH; c++)
      if (rt[c*4+s])
        ssum += q ? (20'h1 << c) : (20'h10 << c);
  endfunction

  // Kinds: 0 I lanes, 1 Q lanes, 2 cascade, 3 complex channel 0, negative discards.
  task automatic chk(int kind, bit mux);
    out_word_t e, g;
    int k;
    k = 0;
    while (u_out_sink.words.size() == 0 && k < 100)
    begin
      @(negedge clk);
      k++;
    end
    if (k == 100)
    begin
      num_errors++;
      $display("mismatch at %0t: no output word", $time);
      return;
    end
    g = u_out_sink.words.pop_front();
    if (kind < 0)
      return;
    e = '0;
    for (int s = 0; s < NUM_SUM; s++)
      e.lane[s] = ssum(s, kind == 1);
    if (kind == 2)
      e.lane = {40'h0, ssum(0, 1) + (ctrl[3] ? casc.q : 20'h0),
                ssum(0, 0) + (ctrl[3] ? casc.i : 20'h0)};
    if (kind == 3)
      e.lane[1] = ssum(0, 1);
    if (kind == 3 && c2)
      e.lane[3] = ssum(2, 1);
    if (!ctrl[6])
      e.lane = '0;
    e.istrobe = ctrl[5] && mux && (kind == 1 ? !ctrl[4] : ctrl[4]);
    e.sync = sy ^ ctrl[7];
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch at %0t: word %h want %h", $time, g, e);
    end
  endtask

  initial
  begin
    #200000;
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict;
  end

  initial
  begin
    {rstn, wr, rd, upd, cv, c0, c2, stall, sy} = '0;
    addr = '0;
    wd = '0;
    sel = 2'd2;
    ch = '0;
    casc = '{i: 20'h30000, q: 20'h03000};
    {ctrl, rt, rtm} = '0;
    {num_errors, num_checks} = '0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    rreg(7'h78, 16'h0000);
    rreg(7'h79, 16'h0000);
    cmp(16'(bist), 16'h0, "bist at reset");
    wreg(7'h78, 16'hFFFF);
    rreg(7'h78, 16'hC7FF);
    cmp(16'(bist), 16'h1, "bist set");
    wreg(7'h10, 16'h1234);
    rreg(7'h10, 16'h0000);
    wreg(7'h78, 16'h0140);
    wreg(7'h10, 16'h0000);
    cmp(16'(bist), 16'h0, "bist clear");
    $display("test registers done");
    wreg(7'h79, 16'h9421);
    rreg(7'h79, 16'h9421);
    push(0);
    chk(0, 0);
    update;
    push(0);
    chk(0, 0);
    wreg(7'h78, 16'h0640);
    push(0);
    chk(1, 0);
    wreg(7'h78, 16'h0100);
    push(0);
    chk(0, 0);
    wreg(7'h78, 16'h0560);
    push(0);
    chk(0, 1);
    push(0);
    chk(1, 1);
    wreg(7'h78, 16'h0140);
    push(0);
    chk(0, 0);
    wreg(7'h78, 16'h03F0);
    for (int k = 0; k < 3; k++)
    begin
      push(0);
      chk(k % 2, 1);
    end
    $display("test formats done");
    wreg(7'h78, 16'h8140);
    wreg(7'h79, 16'h0F0F);
    push(0);
    chk(0, 0);
    repeat (4) @(negedge clk);
    rt = rtm;
    push(0);
    chk(0, 0);
    wreg(7'h78, 16'h0140);
    wreg(7'h79, 16'h5555);
    update;
    c0 = 1'b1;
    c2 = 1'b1;
    push(0);
    chk(3, 0);
    {c0, c2} = 2'h0;
    wreg(7'h79, 16'h1111);
    update;
    wreg(7'h78, 16'h0048);
    push(0);
    chk(2, 0);
    wreg(7'h78, 16'h0040);
    push(0);
    chk(2, 0);
    for (int d = 1; d <= 3; d++)
    begin
      wreg(7'h78, 16'h0048 | 16'(d << 1));
      repeat (d) push(0);
      repeat (d) chk(-1, 0);
      push(1);
      chk(2, 0);
    end
    // The host leaves cascade input off whenever cascade mode is left.
    wreg(7'h78, 16'h0140);
    $display("test routing done");
    @(negedge clk);
    stall <= 1'b1;
    repeat (3) @(negedge clk);
    cv = 1'b1;
    n = 0;
    repeat (40)
    begin
      if (crdy === 1'b1)
        n++;
      @(negedge clk);
    end
    cv = 1'b0;
    cmp(16'(n), 16'(FW + 1), "fill count");
    stall <= 1'b0;
    repeat (60) @(negedge clk);
    cmp(16'(u_out_sink.words.size()), 16'(FW + 1), "drain count");
    cmp(16'(ovld), 16'h0, "drained");
    $display("test buffer done");
    print_verdict;
  end
endmodule
